/* pbi_map.vh */
`ifndef PBI_MAP_VH
`define PBI_MAP_VH
`define PBI_CLK_HZ          20000000
`define PBI_STATUS_BUSY_BIT 6
`define PBI_OP_NONE         4'h0
`define PBI_OP_STORE_ALL    4'h1
`define PBI_OP_RESTORE_ALL  4'h2
`define PBI_OP_LOG_CLEAR    4'h3
`define PBI_OP_LOG_STORE    4'h4
`define PBI_OP_LOG_INTERNAL 4'h5
`define PBI_OP_LOG_RESTORE  4'h6
`define PBI_OP_NVM_ERASE    4'h7
`define PBI_OP_NVM_WORD     4'h8
`define PBI_OP_CFG_WRITE    4'h9
`define PBI_OP_CLEAR_FAULTS 4'hA
`define PBI_T_RESTORE_MS    30
`define PBI_T_LOG_CLEAR_MS  175
`define PBI_T_LOG_STORE_MS  20
`define PBI_T_LOG_REST_MS   2
`define PBI_T_CFG_US        50
`define PBI_T_CLR_US        500
`define PBI_CYC_MS(t)       ((t) * (`PBI_CLK_HZ / 1000))
`define PBI_CYC_CFG         ((`PBI_T_CFG_US * (`PBI_CLK_HZ / 1000000)) - 1)
`define PBI_CYC_CLR         (`PBI_T_CLR_US * (`PBI_CLK_HZ / 1000000))
`endif

/* pbi_sync.v */
`timescale 1ns/100ps
`default_nettype none
module pbi_sync (
  // Clock and reset
  input  wire CLOCK,
  input  wire RST,
  // Data
  input  wire d,
  output reg  q
);
  reg meta_reg;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* pbi_busy_interlock.v */
`timescale 1ns/100ps
`default_nettype none
`include "pbi_map.vh"
module pbi_busy_interlock #(
  parameter [31:0] T_STORE_CYC   = 32'h0009_27C0,
  parameter [31:0] T_RESTORE_CYC = `PBI_CYC_MS(`PBI_T_RESTORE_MS),
  parameter [31:0] T_LOGCLR_CYC  = `PBI_CYC_MS(`PBI_T_LOG_CLEAR_MS),
  parameter [31:0] T_LOGSTO_CYC  = `PBI_CYC_MS(`PBI_T_LOG_STORE_MS),
  parameter [31:0] T_LOGRES_CYC  = `PBI_CYC_MS(`PBI_T_LOG_REST_MS),
  parameter [31:0] T_NVM_CYC     = 32'h0001_86A0,
  parameter [31:0] T_CLR_CYC     = `PBI_CYC_CLR
) (
  // Clock and reset
  input  wire       CLOCK,
  input  wire       RST,
  // Bus framing events from the PMBus slave, same clock
  input  wire       START_SEEN,
  input  wire       STOP_SEEN,
  input  wire       CMD_VALID,
  input  wire       CMD_IS_STATUS_QUERY,
  // Internal operation launched by the last command
  input  wire       OP_VALID,
  input  wire [3:0] OP_KIND,
  // External fault log request pin
  input  wire       FAULT_LOG_REQ,
  // Outcome of the command byte
  output wire       CMD_ACK,
  output wire       CMD_NACK,
  output wire       CMD_EXECUTE,
  // Status
  output reg  [7:0] STATUS_QUERY_DATA,
  output reg        STATUS_WORD_BUSY,
  output reg        BUSY_FAULT,
  output reg        CLEAR_PENDING,
  output wire       CLEAR_DONE,
  input  wire       FAULT_ACK,
  // Alert pin, open drain
  output wire       ALERT_LINE_N_O,
  output wire       ALERT_LINE_N_OE
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_BUSY  = 2'h2;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  reg  [31:0] load_reg;
  reg  [31:0] clr_cnt_reg;
  wire        log_req_sync;
  reg         log_req_d_reg;
  wire        busy;
  wire        refuse;
  wire        log_rise;
  reg         log_wait_reg;
  wire        op_start;
  wire        take_log;
  wire        clear_start;

  function [31:0] op_cycles;
    input [3:0] kind;
    begin
      case (kind)
        `PBI_OP_STORE_ALL:    op_cycles = T_STORE_CYC;
        `PBI_OP_RESTORE_ALL:  op_cycles = T_RESTORE_CYC;
        `PBI_OP_LOG_CLEAR:    op_cycles = T_LOGCLR_CYC;
        `PBI_OP_LOG_STORE:    op_cycles = T_LOGSTO_CYC;
        `PBI_OP_LOG_INTERNAL: op_cycles = T_LOGSTO_CYC;
        `PBI_OP_LOG_RESTORE:  op_cycles = T_LOGRES_CYC;
        `PBI_OP_NVM_ERASE:    op_cycles = T_NVM_CYC;
        `PBI_OP_NVM_WORD:     op_cycles = T_NVM_CYC;
        `PBI_OP_CFG_WRITE:    op_cycles = `PBI_CYC_CFG;
        default:              op_cycles = 32'h0000_0000;
      endcase
    end
  endfunction

  function is_busy;
    input [1:0] st;
    begin
      is_busy = (st != ST_IDLE);
    end
  endfunction

  pbi_sync u_log_sync (
    .CLOCK (CLOCK),
    .RST   (RST),
    .d     (FAULT_LOG_REQ),
    .q     (log_req_sync)
  );

  assign log_rise = log_req_sync & ~log_req_d_reg;
  assign busy     = is_busy(state_reg);
  // Address byte is always acked upstream; only the command byte is judged
  assign refuse      = CMD_VALID & busy & ~CMD_IS_STATUS_QUERY;
  assign CMD_NACK    = refuse;
  assign CMD_ACK     = CMD_VALID & ~refuse;
  assign CMD_EXECUTE = CMD_VALID & ~refuse;
  assign ALERT_LINE_N_O  = 1'b0;
  assign ALERT_LINE_N_OE = BUSY_FAULT;
  assign CLEAR_DONE      = CLEAR_PENDING & (clr_cnt_reg == 32'h0000_0000);
  // An operation launched in the same cycle as a pin request goes first
  assign op_start    = OP_VALID & (op_cycles(OP_KIND) != 32'h0000_0000) & ~busy;
  assign take_log    = ~busy & ~op_start & (log_rise | log_wait_reg);
  assign clear_start = OP_VALID & (OP_KIND == `PBI_OP_CLEAR_FAULTS);

  // Busy timing: armed by the operation, counting starts at the stop
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (op_start) begin
          state_next = ST_ARMED;
        end else if (take_log) begin
          state_next = ST_BUSY;
          cnt_next   = T_LOGSTO_CYC;
        end
      end
      ST_ARMED: begin
        if (STOP_SEEN) begin
          state_next = ST_BUSY;
          cnt_next   = load_reg;
        end
      end
      ST_BUSY: begin
        if (cnt_reg <= 32'h0000_0001) begin
          state_next = ST_IDLE;
          cnt_next   = 32'h0000_0000;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Busy state and its down counter
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Duration is latched with the operation and applied at the stop
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      load_reg <= 32'h0000_0000;
    end else if (op_start) begin
      load_reg <= op_cycles(OP_KIND);
    end
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      log_req_d_reg <= 1'b0;
    end else begin
      log_req_d_reg <= log_req_sync;
    end
  end

  // A pin request that arrives while busy waits for the idle state
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      log_wait_reg <= 1'b0;
    end else if (take_log) begin
      log_wait_reg <= 1'b0;
    end else if (log_rise) begin
      log_wait_reg <= 1'b1;
    end
  end

  // Set wins over acknowledge
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      BUSY_FAULT <= 1'b0;
    end else if (refuse) begin
      BUSY_FAULT <= 1'b1;
    end else if (FAULT_ACK) begin
      BUSY_FAULT <= 1'b0;
    end
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      STATUS_WORD_BUSY <= 1'b0;
    end else if (refuse) begin
      STATUS_WORD_BUSY <= 1'b1;
    end else if (FAULT_ACK) begin
      STATUS_WORD_BUSY <= 1'b0;
    end
  end

  // Registered from the next state each cycle, so it follows the busy state with no lag
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      STATUS_QUERY_DATA <= 8'hFF;
    end else begin
      STATUS_QUERY_DATA <= {1'b1, ~is_busy(state_next), 6'h3F};
    end
  end

  // CLEAR_PENDING clears only when the delay runs out; commands go on meanwhile
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      CLEAR_PENDING <= 1'b0;
      clr_cnt_reg   <= 32'h0000_0000;
    end else if (clear_start) begin
      CLEAR_PENDING <= 1'b1;
      clr_cnt_reg   <= T_CLR_CYC - 32'h0000_0001;
    end else if (CLEAR_PENDING) begin
      if (clr_cnt_reg == 32'h0000_0000) begin
        CLEAR_PENDING <= 1'b0;
      end else begin
        clr_cnt_reg <= clr_cnt_reg - 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

/* pbi_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module pbi_checker (
  // Watched ports of the block
  input wire logic CLOCK, RST, CMD_VALID, CMD_IS_STATUS_QUERY, CMD_ACK, CMD_NACK,
  input wire logic CMD_EXECUTE, BUSY_FAULT, STATUS_WORD_BUSY, FAULT_ACK, ALERT_LINE_N_OE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_refused;
    CMD_NACK ##1 BUSY_FAULT && STATUS_WORD_BUSY;
  endsequence
  one_answer_a: assert property (CMD_VALID |-> CMD_ACK ^ CMD_NACK) else $error("ack");
  status_ack_a:
    assert property (CMD_VALID && CMD_IS_STATUS_QUERY |-> CMD_ACK) else $error("sq");
  refuse_log_a: assert property (CMD_NACK |-> s_refused) else $error("log");
  nack_drop_a: assert property (CMD_NACK |-> !CMD_EXECUTE) else $error("exec");
  quiet_idle_a: assert property (!CMD_VALID |-> !(CMD_ACK | CMD_NACK)) else $error("idle");
  alert_pull_a: assert property (ALERT_LINE_N_OE == BUSY_FAULT) else $error("alert");
  fault_hold_a: assert property (BUSY_FAULT && !FAULT_ACK |=> BUSY_FAULT) else $error("hold");
  fault_clear_a: assert property (FAULT_ACK && !CMD_NACK |=> !BUSY_FAULT) else $error("clr");
  status_safe_a:
    assert property (CMD_VALID && CMD_IS_STATUS_QUERY && !BUSY_FAULT |=> !BUSY_FAULT)
      else $error("sq fault");
endmodule
bind pbi_busy_interlock pbi_checker u_pbi_checker (.*);
`default_nettype wire

/* pbi_host.sv */
`timescale 1ns/100ps
`default_nettype none
module pbi_host (
  // Clock and answer from the block
  input wire logic       clock, ack, nack, exec,
  // Framing events toward the block
  output var logic       start, stop, valid, status, op,
  output var logic [3:0] kind
);
  logic got_ack, got_nack, got_exec;
  initial {start, stop, valid, status, op, kind} = '0;
  // Start, command byte, optional internal operation, then stop
  task xfer(input logic s, input logic o, input logic [3:0] k);
    @(negedge clock) start = 1'b1;
    @(negedge clock) {start, valid, status} = {1'b0, 1'b1, s};
    @(posedge clock) {got_ack, got_nack, got_exec} = {ack, nack, exec};
    @(negedge clock) {valid, op, kind} = {1'b0, o, k};
    @(negedge clock) {op, stop} = 2'b01;
    @(negedge clock) stop = 1'b0;
  endtask
endmodule
`default_nettype wire

/* pmbus_busy_interlock_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: %h %h", $time, a, b); end end
module pmbus_busy_interlock_tb_top;
  logic clock = 1'b0, rst = 1'b1, fault_ack = 1'b0, fault_log = 1'b0;
  logic start, stop, valid, status, op, ack, nack, exec, fault, pend;
  logic swb, done, alert_o, alert_oe;
  logic [3:0] kind;
  logic [7:0] sqd;
  int tests_run = 0, mismatches = 0, cycles = 0, seen = 0;
  always #25 clock = ~clock;
  pbi_busy_interlock #(.T_STORE_CYC(32'h14), .T_RESTORE_CYC(32'h14), .T_LOGCLR_CYC(32'h14),
    .T_LOGSTO_CYC(32'h14), .T_LOGRES_CYC(32'h14), .T_NVM_CYC(32'h14), .T_CLR_CYC(32'h1E))
  u_pbi_busy_interlock (.CLOCK(clock), .RST(rst), .START_SEEN(start), .STOP_SEEN(stop),
    .CMD_VALID(valid), .CMD_IS_STATUS_QUERY(status), .OP_VALID(op), .OP_KIND(kind),
    .FAULT_LOG_REQ(fault_log), .CMD_ACK(ack), .CMD_NACK(nack), .CMD_EXECUTE(exec),
    .STATUS_QUERY_DATA(sqd), .STATUS_WORD_BUSY(swb), .BUSY_FAULT(fault), .CLEAR_PENDING(pend),
    .CLEAR_DONE(done), .FAULT_ACK(fault_ack), .ALERT_LINE_N_O(alert_o),
    .ALERT_LINE_N_OE(alert_oe));
  pbi_host u_pbi_host (.*);
  task send(input logic s, input logic o, input logic [3:0] k, input logic a);
    u_pbi_host.xfer(s, o, k);
    `CHK(u_pbi_host.got_ack, a)
    `CHK(u_pbi_host.got_nack, !a)
    `CHK(u_pbi_host.got_exec, a)
  endtask
  task t_op(input logic [3:0] k, input int n);
    send(1'b0, 1'b1, k, 1'b1);
    repeat (4) @(negedge clock);
    `CHK(sqd, 8'hBF)
    send(1'b0, 1'b0, 4'h0, 1'b0);
    `CHK(fault, 1'b1)
    `CHK(swb, 1'b1)
    `CHK({alert_oe, alert_o}, 2'b10)
    send(1'b1, 1'b0, 4'h0, 1'b1);
    repeat (n) @(negedge clock);
    `CHK(sqd, 8'hFF)
    fault_ack = 1'b1;
    @(negedge clock) fault_ack = 1'b0;
    `CHK(fault, 1'b0)
    `CHK({swb, alert_oe}, 2'b00)
    send(1'b0, 1'b0, 4'h0, 1'b1);
    $display("Op %h done", k);
  endtask
  // Fault log request on the pin makes the block busy on its own
  task t_pin;
    fault_log = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(sqd[6], 1'b0)
    send(1'b0, 1'b0, 4'h0, 1'b0);
    `CHK(fault, 1'b1)
    repeat (20) @(negedge clock);
    `CHK(sqd[6], 1'b1)
    fault_log = 1'b0;
    fault_ack = 1'b1;
    @(negedge clock) fault_ack = 1'b0;
    $display("Pin log done");
  endtask
  task print_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clock);
    rst = 1'b0;
    send(1'b1, 1'b0, 4'h0, 1'b1);
    `CHK(sqd, 8'hFF)
    $display("Idle done");
    t_pin;
    for (int k = 1; k < 10; k++) t_op(4'(k), (k == 9) ? 1000 : 20);
    send(1'b0, 1'b1, 4'hA, 1'b1);
    send(1'b0, 1'b0, 4'h0, 1'b1);
    `CHK(pend, 1'b1)
    repeat (35) @(negedge clock) if (done) seen++;
    `CHK(pend, 1'b0)
    `CHK(seen, 1)
    $display("Clear done");
    print_verdict;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict;
    end
  end
endmodule
`default_nettype wire
